// ---- hw/rx_status_port.sv ----
// Contract
// - Peek read returns head, keeps FIFO.
// - Pop read returns head and removes it.
// - Entry meaning follows host or device mode.
// - Host 0010 IN data; codes 0011, 0101 raise events on pop.
// - Host 0111 halted channel, event on pop.
// - Device 0001, 0011, 0100 raise an event.
// - Device 0010 OUT data, 0110 SETUP data.
// - Bits 16:15 carry the data PID.
// - Bits 14:4 carry the byte count.
// - Host bits 3:0 carry channel index.
// - Device bits 3:0 carry endpoint index.
// - Depth field 15:0, words, 1 to 1024.
// - Reset: depth 0x200, status reads zero.
// - Enable bit 4 gates not-empty interrupt.
// Purpose: Status head of the shared receive FIFO, with peek and pop reads and depth setting.
// Assumes: One clock; the link side pushes entries with valid and ready.
// Notes: The entry store has DEPTH words; rx_fifo_depth limits how many are accepted.
`timescale 1ns/1ps
`include "rx_status_regs.svh"
module rx_status_port #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [3:0] i_in_code,
    input wire logic [1:0] i_in_pid,
    input wire logic [10:0] i_in_count,
    input wire logic [3:0] i_in_index,
    input wire logic i_in_valid,
    output logic o_in_ready,
    output logic o_rx_not_empty_flag,
    output logic o_irq,
    output logic o_event_pulse,
    output logic o_host_mode
);
    import rx_status_pkg::*;

    // Released copy of the reset; two stages so release is clean.
    logic rst_meta_reg;
    logic rst_sync_reg;
    // Two-entry skid buffer between the link and the entry store.
    // Entries keep all 21 bits, so four-bit channel and endpoint numbers survive.
    logic [20:0] skid_data_reg [2];
    logic [1:0] skid_count_reg;
    // Entry store and pointers.
    logic [20:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] fill_reg;
    // Software-visible control.
    logic [15:0] rx_depth_words_reg;
    logic rx_not_empty_irq_enable_reg;
    logic host_mode_reg;
    // Decoded bus strobes, push and pop qualifiers, head decode and read mux.
    logic rd_peek;
    logic rd_pop;
    logic pop_ok;
    logic push_ok;
    logic [20:0] head;
    logic [31:0] head_word;
    logic [AW:0] limit;
    logic head_is_event;
    logic [31:0] rdata_next;

    // Reset release synchroniser; the first stage feeds only the second.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Strobe decode for the two status registers.
    assign rd_peek = i_rd && (i_addr == `RX_STATUS_PEEK_OFFSET);
    assign rd_pop = i_rd && (i_addr == `RX_STATUS_POP_OFFSET);
    // pop only when an entry exists
    assign pop_ok = rd_pop && (fill_reg != '0);
    // Accepted words never exceed the programmed depth nor the store size.
    assign limit = (rx_depth_words_reg > 16'(DEPTH)) ? (AW+1)'(DEPTH) : rx_depth_words_reg[AW:0];
    assign push_ok = (skid_count_reg != 2'd0) && (fill_reg < limit);
    assign head = mem_reg[rd_ptr_reg];

    always_comb
    begin
        head_word = 32'h0000_0000;
        if (fill_reg != '0)
        begin
            head_word[`STATUS_CODE_HI:`STATUS_CODE_LO] = head[20:17];
            head_word[`PID_HI:`PID_LO] = head[16:15];
            head_word[`COUNT_HI:`COUNT_LO] = head[14:4];
            head_word[`INDEX_HI:`INDEX_LO] = head[3:0];
        end
    end

    // Skid buffer: accepts while it has room, so a stalled store loses nothing.
    always_ff @(posedge i_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            skid_count_reg <= 2'd0;
            skid_data_reg[0] <= 21'h000000;
            skid_data_reg[1] <= 21'h000000;
        end
        else
        begin
            if (i_in_valid && o_in_ready && push_ok)
            begin
                skid_data_reg[0] <= (skid_count_reg == 2'd2) ? skid_data_reg[1]
                    : {i_in_code, i_in_pid, i_in_count, i_in_index};
                skid_data_reg[1] <= {i_in_code, i_in_pid, i_in_count, i_in_index};
            end
            else if (i_in_valid && o_in_ready)
            begin
                skid_data_reg[skid_count_reg[0]] <= {i_in_code, i_in_pid, i_in_count, i_in_index};
                skid_count_reg <= skid_count_reg + 2'd1;
            end
            else if (push_ok)
            begin
                skid_data_reg[0] <= skid_data_reg[1];
                skid_count_reg <= skid_count_reg - 2'd1;
            end
        end
    end

    // Ready comes from a flop: room for one more word after this cycle.
    always_ff @(posedge i_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            o_in_ready <= 1'b0;
        end
        else
        begin
            o_in_ready <= (skid_count_reg == 2'd0) || push_ok
                || ((skid_count_reg == 2'd1) && !(i_in_valid && o_in_ready));
        end
    end

    // Entry store write.
    always_ff @(posedge i_clk)
    begin
        if (push_ok)
        begin
            mem_reg[wr_ptr_reg] <= skid_data_reg[0];
        end
    end

    // pointers and fill follow push and pop
    always_ff @(posedge i_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end
        else
        begin
            if (push_ok)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            // peek leaves the read pointer alone
            if (pop_ok)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            fill_reg <= fill_reg + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
        end
    end

    // Software control registers; depth writes outside 1..1024 are ignored.
    always_ff @(posedge i_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            rx_depth_words_reg <= `RX_FIFO_DEPTH_RESET;
            rx_not_empty_irq_enable_reg <= 1'b0;
            host_mode_reg <= 1'b0;
        end
        else if (i_wr)
        begin
            if ((i_addr == `RX_FIFO_DEPTH_OFFSET) && (i_wdata[15:0] >= `RX_DEPTH_MIN)
                && (i_wdata[15:0] <= `RX_DEPTH_MAX))
            begin
                rx_depth_words_reg <= i_wdata[15:0];
            end
            if (i_addr == `RX_IRQ_ENABLE_OFFSET)
            begin
                rx_not_empty_irq_enable_reg <= i_wdata[`NOT_EMPTY_IE_BIT];
            end
            if (i_addr == `RX_CONTROL_OFFSET)
            begin
                host_mode_reg <= i_wdata[`CONTROL_HOST_BIT];
            end
        end
    end

    always_comb
    begin
        head_is_event = 1'b0;
        if (host_mode_reg)
        begin
            case (head[20:17])
                HOST_IN_DONE, HOST_TOGGLE_ERR, HOST_CH_HALTED: head_is_event = 1'b1;
                default: head_is_event = 1'b0;
            endcase
        end
        else
        begin
            case (head[20:17])
                DEV_OUT_NAK, DEV_OUT_DONE, DEV_SETUP_DONE: head_is_event = 1'b1;
                default: head_is_event = 1'b0;
            endcase
        end
    end

    // Read data mux, unmapped addresses read zero.
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (i_addr)
            `RX_STATUS_PEEK_OFFSET: rdata_next = head_word;
            `RX_STATUS_POP_OFFSET: rdata_next = head_word;
            `RX_FIFO_DEPTH_OFFSET: rdata_next = {16'h0000, rx_depth_words_reg};
            `RX_IRQ_ENABLE_OFFSET: rdata_next = {27'h0, rx_not_empty_irq_enable_reg, 4'h0};
            `RX_CONTROL_OFFSET: rdata_next = {31'h0, host_mode_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Registered outputs.
    always_ff @(posedge i_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            o_rdata <= 32'h0000_0000;
            o_rx_not_empty_flag <= 1'b0;
            o_irq <= 1'b0;
            o_event_pulse <= 1'b0;
            o_host_mode <= 1'b0;
        end
        else
        begin
            o_rdata <= i_rd ? rdata_next : 32'h0000_0000;
            o_rx_not_empty_flag <= (fill_reg + (AW+1)'(push_ok) - (AW+1)'(pop_ok)) != '0;
            o_irq <= rx_not_empty_irq_enable_reg && ((fill_reg + (AW+1)'(push_ok) - (AW+1)'(pop_ok)) != '0);
            o_event_pulse <= pop_ok && head_is_event;
            o_host_mode <= host_mode_reg;
        end
    end

    // Assertions.
    property p_peek_keeps;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        (rd_peek && !push_ok) |=> (fill_reg == $past(fill_reg));
    endproperty
    a_peek_keeps: assert property (p_peek_keeps) else $error("Peek changed fill.");

    property p_pop_drops;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        (pop_ok && !push_ok) |=> (fill_reg == $past(fill_reg) - 1'b1);
    endproperty
    a_pop_drops: assert property (p_pop_drops) else $error("Pop did not remove entry.");

    property p_pop_data;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        rd_pop |=> (o_rdata == $past(head_word));
    endproperty
    a_pop_data: assert property (p_pop_data) else $error("Pop read wrong data.");

    property p_host_event;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        (pop_ok && host_mode_reg && head[20:17] == 4'h7) |=> o_event_pulse;
    endproperty
    a_host_event: assert property (p_host_event) else $error("Halted pop gave no event.");

    property p_dev_event;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        (pop_ok && !host_mode_reg && head[20:17] == 4'h4) |=> o_event_pulse;
    endproperty
    a_dev_event: assert property (p_dev_event) else $error("Setup done pop gave no event.");

    property p_data_quiet;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        (pop_ok && !host_mode_reg && head[20:17] == 4'h2) |=> !o_event_pulse;
    endproperty
    a_data_quiet: assert property (p_data_quiet) else $error("Data pop gave an event.");

    property p_depth_range;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        (rx_depth_words_reg >= 16'h0001) && (rx_depth_words_reg <= 16'h0400);
    endproperty
    a_depth_range: assert property (p_depth_range) else $error("Depth out of range.");

    property p_irq_gate;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        o_irq |-> (o_rx_not_empty_flag && $past(rx_not_empty_irq_enable_reg));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("Interrupt without enable.");

    property p_empty_clear;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        (pop_ok && fill_reg == 1 && !push_ok) |=> !o_rx_not_empty_flag;
    endproperty
    a_empty_clear: assert property (p_empty_clear) else $error("Flag stayed after last pop.");

    // The full four-bit index must come back; a narrowed store would drop the upper bits.
    property p_pop_index;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        pop_ok |=> (o_rdata[`INDEX_HI:`INDEX_LO] == $past(head[3:0]));
    endproperty
    a_pop_index: assert property (p_pop_index) else $error("Pop lost index bits.");

    // A pop on an empty store must not hand out a stale entry.
    property p_empty_pop_zero;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        (rd_pop && (fill_reg == '0)) |=> (o_rdata == 32'h0000_0000);
    endproperty
    a_empty_pop_zero: assert property (p_empty_pop_zero) else $error("Empty pop read nonzero.");

    // Events come only from a pop, never from a peek or a push.
    property p_event_after_pop;
        @(posedge i_clk) disable iff (!rst_sync_reg)
        o_event_pulse |-> $past(pop_ok);
    endproperty
    a_event_after_pop: assert property (p_event_after_pop) else $error("Event without pop.");
endmodule : rx_status_port

// ---- hw/rx_status_regs.svh ----
// Purpose: Offsets, field positions, reset values and limits of the receive status port.
// Assumes: Byte addresses on a plain 32-bit register port.
// Notes: Definitions only.
`ifndef RX_STATUS_REGS_SVH
`define RX_STATUS_REGS_SVH
`define RX_STATUS_PEEK_OFFSET 8'h1C
`define RX_STATUS_POP_OFFSET 8'h20
`define RX_FIFO_DEPTH_OFFSET 8'h24
`define RX_IRQ_ENABLE_OFFSET 8'h28
`define RX_CONTROL_OFFSET 8'h2C
`define RX_FIFO_DEPTH_RESET 16'h0200
`define RX_DEPTH_MAX 16'h0400
`define RX_DEPTH_MIN 16'h0001
`define STATUS_CODE_HI 20
`define STATUS_CODE_LO 17
`define PID_HI 16
`define PID_LO 15
`define COUNT_HI 14
`define COUNT_LO 4
`define INDEX_HI 3
`define INDEX_LO 0
`define NOT_EMPTY_IE_BIT 4
`define CONTROL_HOST_BIT 0
`endif

// ---- hw/rx_status_pkg.sv ----
// Purpose: Types shared by the receive status port.
// Assumes: Nothing beyond the header of constants.
// Notes: Codes follow the packet status encoding for each mode.
package rx_status_pkg;
    // Host-mode packet status codes.
    typedef enum logic [3:0] {
        HOST_IN_DATA = 4'h2,
        HOST_IN_DONE = 4'h3,
        HOST_TOGGLE_ERR = 4'h5,
        HOST_CH_HALTED = 4'h7
    } host_status_type;
    // Device-mode packet status codes.
    typedef enum logic [3:0] {
        DEV_OUT_NAK = 4'h1,
        DEV_OUT_DATA = 4'h2,
        DEV_OUT_DONE = 4'h3,
        DEV_SETUP_DONE = 4'h4,
        DEV_SETUP_DATA = 4'h6
    } dev_status_type;
    // Data PID codes.
    typedef enum logic [1:0] {
        PID_DATA0 = 2'h0,
        PID_DATA1 = 2'h2
    } pid_type;
    // Read data selection states.
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_ACTIVE = 2'b01
    } rd_state_type;
endpackage : rx_status_pkg

// ---- bench/link_entry_source.sv ----
// Purpose: Link-side source pushing receive status entries into the port.
// Assumes: The bench queues entries through push_entry after reset.
// Notes: A word is held until ready is sampled high; idle lines carry inverted data.
`timescale 1ns/1ps
module link_entry_source (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_ready,
    output logic [20:0] o_word,
    output logic o_valid
);
    logic [20:0] pend_q[$]; // Entries still to be sent, oldest first.
    logic [20:0] last_word = 21'h0; // Last word sent.
    logic gap = 1'b0; // Forces an idle cycle between words when slow.
    int stall_cnt = 0; // Cycles in which the port refused a word.
    // Queue one entry for the link.
    task automatic push_entry(input logic [20:0] w);
        pend_q.push_back(w);
    endtask : push_entry
    initial
    begin
        o_valid = 1'b0;
        o_word = 21'h1FFFFF;
    end
    // While valid is high, the word and valid change only after an edge where ready took the word.
    always @(posedge i_clk)
    begin
        if (o_valid && !i_ready)
            stall_cnt <= stall_cnt + 1;
        else if (pend_q.size() != 0 && !(i_slow && gap))
        begin
            last_word = pend_q.pop_front();
            o_word <= last_word;
            o_valid <= 1'b1;
            gap = 1'b1;
        end
        else
        begin
            // Released lines show no stale value, so a late sample is caught.
            o_word <= ~last_word;
            o_valid <= 1'b0;
            gap = 1'b0;
        end
    end
endmodule : link_entry_source

// ---- bench/rx_status_port_tb_top.sv ----
// Purpose: Self-checking bench of the receive status port.
// Assumes: Register reads answer one cycle later; entries enter through the link source.
// Notes: Expected reads are queued by the driver and compared by a monitor.
`timescale 1ns/1ps
`include "rx_status_regs.svh"
module rx_status_port_tb_top;
    import rx_status_pkg::*;
    localparam logic [7:0] PK = `RX_STATUS_PEEK_OFFSET;
    localparam logic [7:0] PP = `RX_STATUS_POP_OFFSET;
    localparam logic [7:0] DP = `RX_FIFO_DEPTH_OFFSET;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [20:0] in_word;
    logic in_valid;
    logic o_in_ready;
    logic o_rx_not_empty_flag;
    logic o_irq;
    logic o_event_pulse;
    logic o_host_mode;
    logic slow = 1'b0; // Partner pacing.
    logic rd_pend = 1'b0; // A read answer is due in this cycle.
    logic [32:0] exp_q[$]; // Expected {event, read data}.
    logic [31:0] lfsr = 32'h087A;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    always #20 i_clk = ~i_clk;
    rx_status_port dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_in_code(in_word[20:17]),
        .i_in_pid(in_word[16:15]), .i_in_count(in_word[14:4]), .i_in_index(in_word[3:0]),
        .i_in_valid(in_valid), .o_in_ready(o_in_ready), .o_rx_not_empty_flag(o_rx_not_empty_flag),
        .o_irq(o_irq), .o_event_pulse(o_event_pulse), .o_host_mode(o_host_mode));
    link_entry_source src (.i_clk(i_clk), .i_slow(slow), .i_ready(o_in_ready), .o_word(in_word),
        .o_valid(in_valid));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // Each strobe task sets both strobes once, so no signal is assigned twice in a step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic ev);
        exp_q.push_back({ev, d});
        i_addr <= a;
        i_rd <= 1'b1;
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : rd
    task automatic idle(input int n);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (n) @(posedge i_clk);
    endtask : idle
    // read after flag; returns between edges with the flag seen.
    task automatic wait_flag();
        int n;
        n = 0;
        idle(1);
        @(negedge i_clk);
        while (o_rx_not_empty_flag !== 1'b1 && n < 100)
        begin
            @(negedge i_clk);
            n++;
        end
        check("flag", {31'h0, o_rx_not_empty_flag}, 32'h1);
    endtask : wait_flag
    // Push n entries of the given codes, peek each twice, then pop it.
    task automatic run_mode(input logic host, input logic [79:0] codes, input logic [19:0] evs, input int n);
        logic [31:0] ent[20];
        slow <= host;
        wr(`RX_CONTROL_OFFSET, {31'h0, host});
        wr(`RX_IRQ_ENABLE_OFFSET, host ? 32'h0 : 32'h10);
        for (int k = 0; k < n; k++)
        begin
            lfsr = lfsr_next(lfsr);
            ent[k] = {11'h0, codes[4*k +: 4], lfsr[9] ? 2'h2 : 2'h0, lfsr[20:10], lfsr[3:0]};
            src.push_entry(ent[k][20:0]);
        end
        if (n > 16)
        begin
            // The reader stalls until the store and the skid buffer refuse.
            idle(50);
            @(negedge i_clk);
            check("ready", {31'h0, o_in_ready}, 32'h0);
            @(posedge i_clk);
        end
        wait_flag();
        check("mode", {31'h0, o_host_mode}, {31'h0, host});
        check("irq", {31'h0, o_irq}, {31'h0, ~host});
        @(posedge i_clk);
        for (int k = 0; k < n; k++)
        begin
            wait_flag();
            @(posedge i_clk);
            rd(PK, ent[k], 1'b0);
            rd(PK, ent[k], 1'b0);
            rd(PP, ent[k], evs[k]);
        end
        idle(3);
        @(negedge i_clk);
        check("flag", {31'h0, o_rx_not_empty_flag}, 32'h0);
        check("irq", {31'h0, o_irq}, 32'h0);
        @(posedge i_clk);
    endtask : run_mode
    always @(posedge i_clk)
        rd_pend <= i_rd;
    // Monitor: the answer of each read stands only in the cycle after the strobe.
    always @(negedge i_clk)
    begin
        logic [32:0] e;
        e = 33'h0;
        cycles++;
        if (rd_pend)
        begin
            e = exp_q.pop_front();
            check("rdata", o_rdata, e[31:0]);
        end
        check("event", {31'h0, o_event_pulse}, {31'h0, e[32]});
        if (cycles > 6000)
        begin
            error_cnt++;
            summarize();
        end
    end
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        idle(3);
        rd(PK, 32'h0, 1'b0);
        rd(PP, 32'h0, 1'b0);
        rd(DP, 32'h200, 1'b0);
        wr(DP, 32'h400);
        rd(DP, 32'h400, 1'b0);
        wr(DP, 32'h0);
        wr(DP, 32'h401);
        rd(DP, 32'h400, 1'b0);
        wr(DP, 32'h1);
        rd(DP, 32'h1, 1'b0);
        wr(DP, 32'h200);
        rd(8'h40, 32'h0, 1'b0);
        run_mode(1'b1, 80'h7532, 20'h0E, 4);
        run_mode(1'b0, 80'h64321, 20'h0D, 5);
        run_mode(1'b1, {20{4'h2}}, 20'h0, 20);
        check("stall", (src.stall_cnt > 0) ? 32'h1 : 32'h0, 32'h1);
        idle(3);
        summarize();
    end
endmodule : rx_status_port_tb_top
